// ---- hw/stia_switch_table_access.sv ----
// Indirect register access to the static, reserved multicast and VLAN tables.
// Assumes a register port master that keeps strobes one cycle long and polls the go bits.
`timescale 1ns/1ps
module stia_switch_table_access #(
   parameter int VLAN_IDX_W = 12,
   parameter int STA_IDX_W = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic [stia_pkg::ADDR_W-1:0] regAddr,
   input wire logic [stia_pkg::DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [stia_pkg::DATA_W-1:0] regRdData,
   // VLAN lookup
   input wire logic vlanModeEn,
   input wire logic lookupReq,
   input wire logic [VLAN_IDX_W-1:0] lookupVid,
   output logic vlanInfoValid,
   output stia_pkg::stia_vlan_t vlanInfo,
   // Reserved multicast lookup
   input wire logic [5:0] mcastIdx,
   output logic [stia_pkg::PORTS-1:0] mcastPortMask
);
   typedef struct packed {
      logic [31:0] rdData;
      logic [8:0] e1;
      logic overrideEn;
      logic matchGroupOnMulticast;
      logic [stia_pkg::PORTS-1:0] e2Fwd;
      logic [stia_pkg::GRP_W-1:0] e3Grp;
      logic [stia_pkg::MACHI_W-1:0] e3MacHi;
      logic [31:0] e4;
      logic [stia_pkg::STA_IDX_W-1:0] staIdx;
      logic staAct;
      logic staSel;
      logic goDoneBit;
      stia_pkg::stia_sta_state_t staSt;
      stia_pkg::stia_vlan_t vlEntry;
      logic [VLAN_IDX_W-1:0] vlIdx;
      logic vlAct;
      logic vlGo;
      stia_pkg::stia_vl_state_t vlSt;
      logic [stia_pkg::MCAST_GROUPS-1:0][stia_pkg::PORTS-1:0] mcast;
      logic lkPend;
      logic lkValid;
      stia_pkg::stia_vlan_t lkInfo;
      logic [stia_pkg::PORTS-1:0] mcastOut;
   } stia_state_t;

   stia_state_t state_reg;
   stia_state_t state_next;

   stia_ram_if #(.W(stia_pkg::STA_WORD_W), .AW(STA_IDX_W)) staRam ();
   stia_ram_if #(.W($bits(stia_pkg::stia_vlan_t)), .AW(VLAN_IDX_W)) vlRam ();

   stia_table_ram #(.W(stia_pkg::STA_WORD_W), .AW(STA_IDX_W)) staTable (
      .mclk(mclk),
      .bus(staRam)
   );

   stia_table_ram #(.W($bits(stia_pkg::stia_vlan_t)), .AW(VLAN_IDX_W)) vlTable (
      .mclk(mclk),
      .bus(vlRam)
   );

   // Group of a reserved address; only indices below the entry count are meaningful
   function automatic logic [2:0] mcastGroup(input logic [5:0] idx);
      mcastGroup = 3'(idx / stia_pkg::MCAST_PER_GROUP);
   endfunction

   // Static table runs its write in the go cycle, a read takes one more
   assign staRam.we = state_reg.goDoneBit && (state_reg.staSt == stia_pkg::STA_IDLE)
                      && !state_reg.staSel && !state_reg.staAct;
   assign staRam.addr = state_reg.staIdx[STA_IDX_W-1:0];
   assign staRam.addrB = '0;
   assign staRam.wdata = {state_reg.e1, state_reg.overrideEn, state_reg.matchGroupOnMulticast,
                          state_reg.e2Fwd, state_reg.e3Grp, state_reg.e3MacHi, state_reg.e4};
   assign vlRam.we = state_reg.vlGo && (state_reg.vlSt == stia_pkg::VL_IDLE) && !state_reg.vlAct;
   assign vlRam.addr = state_reg.vlIdx;
   assign vlRam.addrB = lookupVid;
   assign vlRam.wdata = state_reg.vlEntry;

   always_comb begin
      state_next = state_reg;
      // Lookup pipeline: the second port never collides with host accesses
      state_next.lkPend = lookupReq && vlanModeEn;
      state_next.lkValid = state_reg.lkPend;
      if (state_reg.lkPend) begin
         state_next.lkInfo = vlRam.rdataB;
      end
      if (mcastIdx < stia_pkg::MCAST_ENTRIES) begin
         state_next.mcastOut = state_reg.mcast[mcastGroup(mcastIdx)];
      end else begin
         state_next.mcastOut = '0;
      end

      // Register reads; unmapped addresses and reserved bits return zero
      state_next.rdData = stia_pkg::ZERO_WORD;
      if (regRd) begin
         case (regAddr)
            stia_pkg::STA_E1_OFF: begin
               state_next.rdData[stia_pkg::E1_VALID_POS] = state_reg.e1[8];
               state_next.rdData[stia_pkg::E1_SRC_POS] = state_reg.e1[7];
               state_next.rdData[stia_pkg::E1_DST_POS] = state_reg.e1[6];
               state_next.rdData[stia_pkg::E1_PRIO_LSB +: 3] = state_reg.e1[5:3];
               state_next.rdData[stia_pkg::E1_SPAN_LSB +: 3] = state_reg.e1[2:0];
            end
            stia_pkg::STA_E2_OFF: begin
               state_next.rdData[stia_pkg::E2_OVR_POS] = state_reg.overrideEn;
               state_next.rdData[stia_pkg::E2_MATCH_POS] = state_reg.matchGroupOnMulticast;
               state_next.rdData[stia_pkg::E2_FWD_LSB +: stia_pkg::PORTS] = state_reg.e2Fwd;
            end
            stia_pkg::STA_E3_OFF: begin
               state_next.rdData[stia_pkg::E3_GRP_LSB +: stia_pkg::GRP_W] = state_reg.e3Grp;
               state_next.rdData[stia_pkg::MACHI_W-1:0] = state_reg.e3MacHi;
            end
            stia_pkg::STA_E4_OFF: begin
               state_next.rdData = state_reg.e4;
            end
            stia_pkg::STA_CTRL_OFF: begin
               state_next.rdData[stia_pkg::STA_IDX_LSB +: stia_pkg::STA_IDX_W] = state_reg.staIdx;
               state_next.rdData[stia_pkg::STA_SEL_POS] = state_reg.staSel;
               state_next.rdData[stia_pkg::STA_ACT_POS] = state_reg.staAct;
               state_next.rdData[stia_pkg::STA_GO_POS] = state_reg.goDoneBit;
            end
            stia_pkg::VL_E0_OFF: begin
               state_next.rdData[stia_pkg::VL_VALID_POS] = state_reg.vlEntry.valid;
               state_next.rdData[stia_pkg::VL_FWDOPT_POS] = state_reg.vlEntry.forwardOption;
               state_next.rdData[stia_pkg::VL_PRIO_LSB +: 3] = state_reg.vlEntry.vlanPriority;
               state_next.rdData[stia_pkg::VL_SPAN_LSB +: 3] = state_reg.vlEntry.spanningInstanceIndex;
               state_next.rdData[stia_pkg::VL_GRP_LSB +: stia_pkg::GRP_W] = state_reg.vlEntry.filterGroupId;
            end
            stia_pkg::VL_E1_OFF: begin
               state_next.rdData[stia_pkg::VL_UNTAG_LSB +: stia_pkg::PORTS] = state_reg.vlEntry.untagMask;
            end
            stia_pkg::VL_E2_OFF: begin
               state_next.rdData[stia_pkg::VL_MEMBER_LSB +: stia_pkg::PORTS] = state_reg.vlEntry.memberMask;
            end
            stia_pkg::VL_IDX_OFF: begin
               state_next.rdData[VLAN_IDX_W-1:0] = state_reg.vlIdx;
            end
            stia_pkg::VL_CTRL_OFF: begin
               state_next.rdData[stia_pkg::VL_GO_POS] = state_reg.vlGo;
               state_next.rdData[stia_pkg::VL_ACT_POS] = state_reg.vlAct;
            end
            default: begin
               state_next.rdData = stia_pkg::ZERO_WORD;
            end
         endcase
      end

      // Register writes; only defined fields are stored
      if (regWr) begin
         case (regAddr)
            stia_pkg::STA_E1_OFF: begin
               state_next.e1 = {regWrData[stia_pkg::E1_VALID_POS], regWrData[stia_pkg::E1_SRC_POS],
                                regWrData[stia_pkg::E1_DST_POS], regWrData[stia_pkg::E1_PRIO_LSB +: 3],
                                regWrData[stia_pkg::E1_SPAN_LSB +: 3]};
            end
            stia_pkg::STA_E2_OFF: begin
               state_next.overrideEn = regWrData[stia_pkg::E2_OVR_POS];
               state_next.matchGroupOnMulticast = regWrData[stia_pkg::E2_MATCH_POS];
               state_next.e2Fwd = regWrData[stia_pkg::E2_FWD_LSB +: stia_pkg::PORTS];
            end
            stia_pkg::STA_E3_OFF: begin
               state_next.e3Grp = regWrData[stia_pkg::E3_GRP_LSB +: stia_pkg::GRP_W];
               state_next.e3MacHi = regWrData[stia_pkg::MACHI_W-1:0];
            end
            stia_pkg::STA_E4_OFF: begin
               state_next.e4 = regWrData;
            end
            stia_pkg::STA_CTRL_OFF: begin
               // Refused while busy so an operation in flight keeps its index and action
               if (!state_reg.goDoneBit) begin
                  state_next.staIdx = regWrData[stia_pkg::STA_IDX_LSB +: stia_pkg::STA_IDX_W];
                  state_next.staSel = regWrData[stia_pkg::STA_SEL_POS];
                  state_next.staAct = regWrData[stia_pkg::STA_ACT_POS];
                  state_next.goDoneBit = regWrData[stia_pkg::STA_GO_POS];
               end
            end
            stia_pkg::VL_E0_OFF: begin
               state_next.vlEntry.valid = regWrData[stia_pkg::VL_VALID_POS];
               state_next.vlEntry.forwardOption = regWrData[stia_pkg::VL_FWDOPT_POS];
               state_next.vlEntry.vlanPriority = regWrData[stia_pkg::VL_PRIO_LSB +: 3];
               state_next.vlEntry.spanningInstanceIndex = regWrData[stia_pkg::VL_SPAN_LSB +: 3];
               state_next.vlEntry.filterGroupId = regWrData[stia_pkg::VL_GRP_LSB +: stia_pkg::GRP_W];
            end
            stia_pkg::VL_E1_OFF: begin
               state_next.vlEntry.untagMask = regWrData[stia_pkg::VL_UNTAG_LSB +: stia_pkg::PORTS];
            end
            stia_pkg::VL_E2_OFF: begin
               state_next.vlEntry.memberMask = regWrData[stia_pkg::VL_MEMBER_LSB +: stia_pkg::PORTS];
            end
            stia_pkg::VL_IDX_OFF: begin
               if (!state_reg.vlGo) begin
                  state_next.vlIdx = regWrData[VLAN_IDX_W-1:0];
               end
            end
            stia_pkg::VL_CTRL_OFF: begin
               if (!state_reg.vlGo) begin
                  state_next.vlAct = regWrData[stia_pkg::VL_ACT_POS];
                  state_next.vlGo = regWrData[stia_pkg::VL_GO_POS];
               end
            end
            default: begin
            end
         endcase
      end

      // Static and reserved multicast engine; completion overrides a host data write
      unique case (state_reg.staSt)
         stia_pkg::STA_IDLE: begin
            if (state_reg.goDoneBit) begin
               if (state_reg.staSel) begin
                  if (state_reg.staIdx < stia_pkg::MCAST_ENTRIES) begin
                     if (state_reg.staAct) begin
                        state_next.e2Fwd = state_reg.mcast[mcastGroup(state_reg.staIdx)];
                     end else begin
                        state_next.mcast[mcastGroup(state_reg.staIdx)] = state_reg.e2Fwd;
                     end
                  end else if (state_reg.staAct) begin
                     state_next.e2Fwd = '0;
                  end
                  state_next.goDoneBit = 1'b0;
               end else if (state_reg.staAct) begin
                  state_next.staSt = stia_pkg::STA_RDWAIT;
               end else begin
                  state_next.goDoneBit = 1'b0;
               end
            end
         end
         stia_pkg::STA_RDWAIT: begin
            {state_next.e1, state_next.overrideEn, state_next.matchGroupOnMulticast, state_next.e2Fwd,
             state_next.e3Grp, state_next.e3MacHi, state_next.e4} = staRam.rdata;
            state_next.goDoneBit = 1'b0;
            state_next.staSt = stia_pkg::STA_IDLE;
         end
      endcase

      // VLAN engine
      unique case (state_reg.vlSt)
         stia_pkg::VL_IDLE: begin
            if (state_reg.vlGo) begin
               if (state_reg.vlAct) begin
                  state_next.vlSt = stia_pkg::VL_RDWAIT;
               end else begin
                  state_next.vlGo = 1'b0;
               end
            end
         end
         stia_pkg::VL_RDWAIT: begin
            state_next.vlEntry = vlRam.rdata;
            state_next.vlGo = 1'b0;
            state_next.vlSt = stia_pkg::VL_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign regRdData = state_reg.rdData;
   assign vlanInfoValid = state_reg.lkValid;
   assign vlanInfo = state_reg.lkInfo;
   assign mcastPortMask = state_reg.mcastOut;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_go_self_clear: assert property (
      $rose(state_reg.goDoneBit) |-> ##[1:2] !state_reg.goDoneBit)
      else $error("static go bit did not clear");

   a_vlgo_self_clear: assert property (
      $rose(state_reg.vlGo) |-> ##[1:2] !state_reg.vlGo)
      else $error("VLAN go bit did not clear");

   a_mcast_group_write: assert property (
      (state_reg.staSt == stia_pkg::STA_IDLE && state_reg.goDoneBit && state_reg.staSel && !state_reg.staAct
       && state_reg.staIdx < stia_pkg::MCAST_ENTRIES)
      |=> (state_reg.mcast[mcastGroup($past(state_reg.staIdx))] == $past(state_reg.e2Fwd)) && !state_reg.goDoneBit)
      else $error("multicast group mask not written");

   a_mcast_read_back: assert property (
      (state_reg.staSt == stia_pkg::STA_IDLE && state_reg.goDoneBit && state_reg.staSel && state_reg.staAct
       && state_reg.staIdx < stia_pkg::MCAST_ENTRIES)
      |=> state_reg.e2Fwd == $past(state_reg.mcast[mcastGroup(state_reg.staIdx)]))
      else $error("multicast read did not reach word 2");

   a_mcast_lookup: assert property (
      (mcastIdx < stia_pkg::MCAST_ENTRIES) |=> mcastPortMask == $past(state_reg.mcast[mcastGroup(mcastIdx)]))
      else $error("multicast lookup mask wrong");

   a_word2_reserved: assert property (
      (regRd && regAddr == stia_pkg::STA_E2_OFF) |=> regRdData[29:7] == '0 && regRdData[6:0] == $past(state_reg.e2Fwd))
      else $error("word 2 readback wrong");

   a_word3_layout: assert property (
      (regRd && regAddr == stia_pkg::STA_E3_OFF)
      |=> regRdData[31:23] == '0 && regRdData[22:16] == $past(state_reg.e3Grp))
      else $error("word 3 layout wrong");

   a_word2_store: assert property (
      (regWr && regAddr == stia_pkg::STA_E2_OFF && state_reg.staSt == stia_pkg::STA_IDLE && !state_reg.goDoneBit)
      |=> state_reg.overrideEn == $past(regWrData[31]) && state_reg.matchGroupOnMulticast == $past(regWrData[30])
          && state_reg.e2Fwd == $past(regWrData[6:0]))
      else $error("word 2 write not stored");

   a_vlan_lookup: assert property (
      (lookupReq && vlanModeEn) |-> ##2 vlanInfoValid)
      else $error("VLAN lookup result missing");

   a_vlan_read_result: assert property (
      (state_reg.vlSt == stia_pkg::VL_RDWAIT) |=> state_reg.vlEntry == $past(vlRam.rdata) && !state_reg.vlGo)
      else $error("VLAN read result not loaded");

   c_mcast_write: cover property (
      state_reg.goDoneBit && state_reg.staSel && !state_reg.staAct ##1 !state_reg.goDoneBit);
   c_static_read: cover property (state_reg.staSt == stia_pkg::STA_RDWAIT);
   c_vlan_write: cover property (vlRam.we);
   c_vlan_lookup: cover property (vlanInfoValid && vlanInfo.valid);
endmodule

// ---- hw/stia_pkg.sv ----
// Constants, field layouts and types for the switch table indirect access block.
// Assumes a 16-bit byte address on the register port and 32-bit data words.
package stia_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int PORTS = 7;

   // Register byte offsets
   localparam logic [15:0] VL_E0_OFF = 16'h0400;
   localparam logic [15:0] VL_E1_OFF = 16'h0404;
   localparam logic [15:0] VL_E2_OFF = 16'h0408;
   localparam logic [15:0] VL_IDX_OFF = 16'h040C;
   localparam logic [15:0] VL_CTRL_OFF = 16'h0410;
   localparam logic [15:0] STA_CTRL_OFF = 16'h0418;
   localparam logic [15:0] STA_E1_OFF = 16'h0420;
   localparam logic [15:0] STA_E2_OFF = 16'h0424;
   localparam logic [15:0] STA_E3_OFF = 16'h0428;
   localparam logic [15:0] STA_E4_OFF = 16'h042C;

   // Reset and unmapped value
   localparam logic [31:0] ZERO_WORD = 32'h00000000;

   // Static entry word 1
   localparam int E1_VALID_POS = 31;
   localparam int E1_SRC_POS = 30;
   localparam int E1_DST_POS = 29;
   localparam int E1_PRIO_LSB = 26;
   localparam int E1_SPAN_LSB = 0;
   // Static entry word 2 and reserved multicast word
   localparam int E2_OVR_POS = 31;
   localparam int E2_MATCH_POS = 30;
   localparam int E2_FWD_LSB = 0;
   // Static entry word 3
   localparam int E3_GRP_LSB = 16;
   localparam int GRP_W = 7;
   localparam int MACHI_W = 16;

   // Static and reserved multicast control word
   localparam int STA_GO_POS = 7;
   localparam int STA_ACT_POS = 6;
   localparam int STA_SEL_POS = 5;
   localparam int STA_IDX_LSB = 16;
   localparam int STA_IDX_W = 6;

   // VLAN control, index and data words
   localparam int VL_GO_POS = 7;
   localparam int VL_ACT_POS = 0;
   localparam int VL_VALID_POS = 31;
   localparam int VL_FWDOPT_POS = 30;
   localparam int VL_PRIO_LSB = 24;
   localparam int VL_SPAN_LSB = 16;
   localparam int VL_GRP_LSB = 0;
   localparam int VL_UNTAG_LSB = 0;
   localparam int VL_MEMBER_LSB = 0;

   // Reserved multicast table shape
   localparam logic [5:0] MCAST_ENTRIES = 6'h30;
   localparam int MCAST_GROUPS = 8;
   localparam logic [5:0] MCAST_PER_GROUP = 6'h06;

   localparam int STA_WORD_W = 73;

   typedef struct packed {
      logic valid;
      logic forwardOption;
      logic [2:0] vlanPriority;
      logic [2:0] spanningInstanceIndex;
      logic [6:0] filterGroupId;
      logic [6:0] untagMask;
      logic [6:0] memberMask;
   } stia_vlan_t;

   typedef enum logic {STA_IDLE, STA_RDWAIT} stia_sta_state_t;
   typedef enum logic {VL_IDLE, VL_RDWAIT} stia_vl_state_t;
endpackage

// ---- hw/stia_ram_if.sv ----
// Table memory access bundle between the register logic and a table memory.
// Assumes one write/read port and one read-only port, both with one cycle latency.
`timescale 1ns/1ps
interface stia_ram_if #(parameter int W = 8, parameter int AW = 4);
   logic we;
   logic [AW-1:0] addr;
   logic [AW-1:0] addrB;
   logic [W-1:0] wdata;
   logic [W-1:0] rdata;
   logic [W-1:0] rdataB;
   modport user (output we, output addr, output addrB, output wdata, input rdata, input rdataB);
   modport mem (input we, input addr, input addrB, input wdata, output rdata, output rdataB);
endinterface

// ---- hw/stia_table_ram.sv ----
// Table memory with a host port and a lookup read port.
// Assumes the user keeps addresses inside the depth; contents are not reset.
`timescale 1ns/1ps
module stia_table_ram #(
   parameter int W = 8,
   parameter int AW = 4
) (
   // Clock
   input wire logic mclk,
   // Access bundle
   stia_ram_if.mem bus
);
   logic [W-1:0] mem [2**AW];

   // Contents are left unreset so the array maps onto block memory
   always_ff @(posedge mclk) begin
      if (bus.we) begin
         mem[bus.addr] <= bus.wdata;
      end
      bus.rdata <= mem[bus.addr];
      bus.rdataB <= mem[bus.addrB];
   end
endmodule

// ---- bench/stia_host_model.sv ----
// Host processor model driving the table access register port.
// Assumes callers run one access at a time; strobes move only after mclk edges.
`timescale 1ns/1ps
module stia_host_model (
   // Clock
   input wire logic mclk,
   // Register port
   output logic [stia_pkg::ADDR_W-1:0] regAddr,
   output logic [stia_pkg::DATA_W-1:0] regWrData,
   output logic regWr,
   output logic regRd,
   input wire logic [stia_pkg::DATA_W-1:0] regRdData
);
   initial begin
      regAddr = 16'h0000;
      regWrData = 32'h00000000;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
      // Released data must not look like a still valid word
      regWrData <= ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask
   // Gives up after 16 polls so a stuck go bit shows as a mismatch, not a hang
   task automatic poll(input logic [15:0] a, output logic [31:0] d);
      for (int i = 0; i < 16; i++) begin
         rd(a, d);
         if (d[7] === 1'b0) break;
      end
   endtask
endmodule

// ---- bench/switch_table_indirect_access_tb.sv ----
// Self-checking bench for the switch table indirect access block.
// Assumes the host model owns the register port; lookup inputs are driven here.
`timescale 1ns/1ps
module switch_table_indirect_access_tb;
   logic mclk, rst_n, vlanModeEn, lookupReq, regWr, regRd, vlanInfoValid;
   logic [11:0] lookupVid;
   logic [5:0] mcastIdx;
   logic [6:0] mcastPortMask;
   logic [15:0] regAddr;
   logic [31:0] regWrData, regRdData, d;
   stia_pkg::stia_vlan_t vlanInfo;
   int err_count = 0;
   int tests_run = 0;
   logic [31:0] sw [4] = '{32'hA0000005, 32'h4000002A, 32'h0055ABCD, 32'h12345678};
   logic [31:0] vw [3] = '{32'hC502007F, 32'h0000002A, 32'h00000041};
   stia_switch_table_access i_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .vlanModeEn(vlanModeEn), .lookupReq(lookupReq),
      .lookupVid(lookupVid), .vlanInfoValid(vlanInfoValid), .vlanInfo(vlanInfo), .mcastIdx(mcastIdx),
      .mcastPortMask(mcastPortMask));
   stia_host_model i_host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input string n, input logic [15:0] a, input logic [31:0] e);
      logic [31:0] v;
      i_host.rd(a, v);
      chk(n, e, v);
   endtask
   task automatic lookup(input logic en, input logic [31:0] e);
      @(posedge mclk);
      vlanModeEn <= en;
      lookupReq <= 1'b1;
      lookupVid <= 12'hFFF;
      @(posedge mclk);
      lookupReq <= 1'b0;
      @(posedge mclk);
      #1;
      chk("lookup valid", {31'h0, en}, {31'h0, vlanInfoValid});
      if (en) chk("lookup info", e, {3'h0, vlanInfo});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #20000;
      err_count++;
      tally_and_finish();
   end
   initial begin
      rst_n = 1'b0;
      vlanModeEn = 1'b0;
      lookupReq = 1'b0;
      lookupVid = 12'h000;
      mcastIdx = 6'h00;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      rdchk("word4 reset", stia_pkg::STA_E4_OFF, stia_pkg::ZERO_WORD);
      rdchk("unmapped", 16'h0500, stia_pkg::ZERO_WORD);
      i_host.wr(stia_pkg::STA_E2_OFF, 32'h00000055);
      i_host.wr(stia_pkg::STA_CTRL_OFF, 32'h000700A0);
      i_host.poll(stia_pkg::STA_CTRL_OFF, d);
      chk("mcast go", 32'h0, d & 32'h80);
      for (int i = 5; i < 13; i++) begin
         @(posedge mclk);
         mcastIdx <= 6'(i);
         @(posedge mclk);
         #1;
         chk("mcast mask", (i >= 6 && i <= 11) ? 32'h55 : 32'h0, {25'h0, mcastPortMask});
      end
      // Indices past the 48 reserved addresses must not alias onto a group
      @(posedge mclk);
      mcastIdx <= 6'h30;
      @(posedge mclk);
      #1;
      chk("mcast beyond table", 32'h0, {25'h0, mcastPortMask});
      i_host.wr(stia_pkg::STA_E2_OFF, 32'h0);
      i_host.wr(stia_pkg::STA_CTRL_OFF, 32'h000A00E0);
      i_host.poll(stia_pkg::STA_CTRL_OFF, d);
      rdchk("mcast read", stia_pkg::STA_E2_OFF, 32'h00000055);
      i_host.wr(stia_pkg::STA_E2_OFF, 32'hFFFFFFFF);
      rdchk("word2 reserved", stia_pkg::STA_E2_OFF, 32'hC000007F);
      i_host.wr(stia_pkg::STA_E3_OFF, 32'hFFFFFFFF);
      rdchk("word3 reserved", stia_pkg::STA_E3_OFF, 32'h007FFFFF);
      for (int i = 0; i < 4; i++) i_host.wr(stia_pkg::STA_E1_OFF + 16'(4 * i), sw[i]);
      i_host.wr(stia_pkg::STA_CTRL_OFF, 32'h00030080);
      i_host.poll(stia_pkg::STA_CTRL_OFF, d);
      for (int i = 0; i < 4; i++) i_host.wr(stia_pkg::STA_E1_OFF + 16'(4 * i), 32'h0);
      i_host.wr(stia_pkg::STA_CTRL_OFF, 32'h000300C0);
      i_host.poll(stia_pkg::STA_CTRL_OFF, d);
      chk("static go", 32'h0, d & 32'h80);
      for (int i = 0; i < 4; i++) rdchk("static word", stia_pkg::STA_E1_OFF + 16'(4 * i), sw[i]);
      for (int i = 0; i < 3; i++) i_host.wr(stia_pkg::VL_E0_OFF + 16'(4 * i), vw[i]);
      i_host.wr(stia_pkg::VL_IDX_OFF, 32'h00000FFF);
      i_host.wr(stia_pkg::VL_CTRL_OFF, 32'h00000080);
      i_host.poll(stia_pkg::VL_CTRL_OFF, d);
      chk("vlan go", 32'h0, d & 32'h80);
      for (int i = 0; i < 3; i++) i_host.wr(stia_pkg::VL_E0_OFF + 16'(4 * i), 32'h0);
      i_host.wr(stia_pkg::VL_CTRL_OFF, 32'h00000081);
      i_host.poll(stia_pkg::VL_CTRL_OFF, d);
      for (int i = 0; i < 3; i++) rdchk("vlan word", stia_pkg::VL_E0_OFF + 16'(4 * i), vw[i]);
      lookup(1'b0, 32'h0);
      // Mode is only turned on once the entry has been programmed
      lookup(1'b1, {3'h0, 1'b1, 1'b1, 3'h5, 3'h2, 7'h7F, 7'h2A, 7'h41});
      tally_and_finish();
   end
endmodule
